// ==== psc_ctrl_model.sv ====
// Controller model supplying write data to the burst SRAM
`timescale 1ns/1ps
`include "psc_defines.vh"
// ======
// Write data timing
module psc_ctrl_model (
	input  wire                   mclk,
	input  wire                   qual,
	input  wire                   wr_req,
	input  wire [`PSC_WORD_W-1:0] wr_word,
	output wire [`PSC_DATA_W-1:0] data_io_in,
	output wire [`PSC_LANES-1:0]  parity_io_in
);
	reg                   v1_reg = 1'b0, v2_reg = 1'b0;
	reg [`PSC_WORD_W-1:0] d1_reg = 36'h0, d2_reg = 36'h0, last_reg = 36'h0;
	always @(posedge mclk) begin
		if (qual) begin
			v1_reg <= wr_req;
			d1_reg <= wr_word;
			v2_reg <= v1_reg;
			d2_reg <= d1_reg;
		end
		if (v2_reg)
			last_reg <= d2_reg;
	end
	// Released lines show inverted last word
	assign {parity_io_in, data_io_in} = v2_reg ? d2_reg : ~last_reg;
endmodule // psc_ctrl_model

// ==== psc_defines.vh ====
// Constants for the burst SRAM cycle decoder
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH

// Array geometry
`define PSC_ADDR_W      18
`define PSC_DEPTH       262144
`define PSC_LANES       4
`define PSC_DATA_W      32
`define PSC_WORD_W      36
`define PSC_LANE_W      8

// Decoded cycle kinds
`define PSC_OP_W        2
`define PSC_OP_DESEL    2'h0
`define PSC_OP_READ     2'h1
`define PSC_OP_WRITE    2'h2
`define PSC_OP_ABORT    2'h3

// Burst in progress
`define PSC_BURST_W     2
`define PSC_BURST_NONE  2'h0
`define PSC_BURST_READ  2'h1
`define PSC_BURST_WRITE 2'h2

// Burst counter step and reset values
`define PSC_CNT_ONE     2'h1
`define PSC_CNT_RESET   2'h0

// Lane select group idle, all high
`define PSC_LANES_IDLE  4'hF

// Sleep entry and exit time in clock cycles
`define PSC_SLEEP_CYCLES 2

// Write buffer depth
`define PSC_BUF_DEPTH   2
`define PSC_BUF_CNT_W   2
`define PSC_BUF_FULL    2'h2

`endif

// ==== psc_sram.v ====
// Cycle decoder, burst counter and array of a pipelined burst SRAM
//
// Operation
// R1: Begin read at external address when selected, load low, write strobe high.
// R2: Load high after read continues at next burst address ignoring selects.
// R3: Read begun with drive enable inactive is a dummy read, pins released.
// R4: Read continued with drive enable inactive advances address, pins released.
// R5: Selected, load low, strobe low, any lane low begins a write burst.
// R6: Load high in write burst with any lane low writes next address.
// R7: Write begin with all lanes high is an abort, memory untouched.
// R8: Write continue with all lanes high advances address, memory untouched.
// R9: Clock qualifier high ignores the edge, freezing address and state.
// R10: Power-up state is deselected with all data pins released.
// R11: Any decoded write releases all data and parity pins.
// R12: Drive enable acts without clocking and is masked during writes.
// R13: Read data driven only while drive enable active and device selected.
// R14: Write strobe high means read regardless of lane selects.
// R15: Each low lane writes its byte and parity, others unaltered.
// R16: Lane select group counts active when any single lane is low.
// R17: Load low with any select inactive deselects; load high continues it.
// R18: Sleep input overrides everything, releases pins, two cycles in and out.
// R19: Burst steps two low address bits interleaved, or linear when grounded.
// R20: Controller presents write data two qualified edges after the command.
`timescale 1ns/1ps
`include "psc_defines.vh"

module psc_sram (
	input  wire                      mclk,
	input  wire                      rstn,
	input  wire                      clock_qualify_n,
	input  wire                      sleep_request,
	input  wire                      burst_mode,
	input  wire                      chip_sel1_n,
	input  wire                      chip_sel2,
	input  wire                      chip_sel3_n,
	input  wire                      advance_load,
	input  wire                      write_n,
	input  wire [`PSC_LANES-1:0]     byte_lane_select,
	input  wire                      output_drive_n,
	input  wire [`PSC_ADDR_W-1:0]    addr,
	input  wire [`PSC_DATA_W-1:0]    data_io_in,
	output wire [`PSC_DATA_W-1:0]    data_io_out,
	output wire                      data_io_oe,
	input  wire [`PSC_LANES-1:0]     parity_io_in,
	output wire [`PSC_LANES-1:0]     parity_io_out,
	output wire                      parity_io_oe,
	output wire                      sleep_active,
	output wire                      write_buffer_ready
);

	// =========================================================
	// Merge and burst arithmetic
	// =========================================================
	function [`PSC_WORD_W-1:0] lane_merge;
		input [`PSC_WORD_W-1:0] base;
		input [`PSC_WORD_W-1:0] nw;
		input [`PSC_LANES-1:0]  lanes_n;
		integer i;
		reg [`PSC_WORD_W-1:0] r;
		begin
			r = base;
			for (i = 0; i < `PSC_LANES; i = i + 1) begin
				if (!lanes_n[i]) begin
					r[i*`PSC_LANE_W +: `PSC_LANE_W] = nw[i*`PSC_LANE_W +: `PSC_LANE_W];
					r[`PSC_DATA_W + i] = nw[`PSC_DATA_W + i];
				end
			end
			lane_merge = r;
		end
	endfunction

	function [1:0] burst_low;
		input [1:0] start;
		input [1:0] cnt;
		input       interleave;
		begin
			if (interleave)
				burst_low = start ^ cnt;
			else
				burst_low = start + cnt;
		end
	endfunction

	// =========================================================
	// Pin synchronisers for sleep and burst mode
	// =========================================================
	reg sleep_meta_reg;
	reg sleep_sync_reg;
	reg mode_meta_reg;
	reg mode_sync_reg;

	// Free-running, so sleep is seen while stalled
	// Mode pin should change only while deselected
	// R18: two-stage entry and exit
	always @(posedge mclk) begin
		sleep_meta_reg <= sleep_request;
		sleep_sync_reg <= sleep_meta_reg;
		mode_meta_reg  <= burst_mode;
		mode_sync_reg  <= mode_meta_reg;
	end

	assign sleep_active = sleep_sync_reg;

	// =========================================================
	// Storage and write buffer
	// =========================================================
	// Array has no reset; contents survive rstn
	reg [`PSC_WORD_W-1:0]    mem_reg [0:`PSC_DEPTH-1];
	reg [`PSC_ADDR_W-1:0]    ent_addr_reg [0:`PSC_BUF_DEPTH-1];
	reg [`PSC_WORD_W-1:0]    ent_data_reg [0:`PSC_BUF_DEPTH-1];
	reg [`PSC_LANES-1:0]     ent_lanes_reg [0:`PSC_BUF_DEPTH-1];
	reg                      rd_ptr_reg;
	reg                      wr_ptr_reg;
	reg [`PSC_BUF_CNT_W-1:0] buf_cnt_reg;

	// =========================================================
	// Pipeline and burst state
	// =========================================================
	reg [`PSC_BURST_W-1:0]   burst_reg;
	reg [`PSC_ADDR_W-1:0]    base_addr_reg;
	reg [1:0]                cnt_reg;
	reg [`PSC_OP_W-1:0]      s1_op_reg;
	reg [`PSC_ADDR_W-1:0]    s1_addr_reg;
	reg [`PSC_LANES-1:0]     s1_lanes_reg;
	reg [`PSC_OP_W-1:0]      s2_op_reg;
	reg [`PSC_ADDR_W-1:0]    s2_addr_reg;
	reg [`PSC_LANES-1:0]     s2_lanes_reg;
	reg [`PSC_WORD_W-1:0]    rd_data_reg;

	reg [`PSC_OP_W-1:0]      op_next;
	reg [`PSC_BURST_W-1:0]   burst_next;
	reg [`PSC_ADDR_W-1:0]    base_addr_next;
	reg [1:0]                cnt_next;
	reg [`PSC_ADDR_W-1:0]    acc_addr_next;
	reg [`PSC_WORD_W-1:0]    rd_data_next;

	wire all_selected;
	wire lanes_active;
	wire push_valid;
	wire drain_valid;
	wire drain_ready;
	wire pipe_en;
	wire buf_full;
	wire push_fire;
	wire drain_fire;
	wire [`PSC_WORD_W-1:0] push_word;

	assign all_selected = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
	// R16: any low lane makes the group active
	assign lanes_active = (byte_lane_select != `PSC_LANES_IDLE);

	// R20: data phase of a write sits in stage two
	// R15: only writes with a selected lane reach the buffer
	assign push_valid  = (s2_op_reg == `PSC_OP_WRITE) && (s2_lanes_reg != `PSC_LANES_IDLE);
	assign push_word   = {parity_io_in, data_io_in};
	assign drain_valid = (buf_cnt_reg != `PSC_CNT_RESET);
	assign drain_ready = !sleep_sync_reg;
	assign buf_full    = (buf_cnt_reg == `PSC_BUF_FULL);
	// Drain stops in sleep, so a full buffer must refuse a push
	assign write_buffer_ready = !buf_full || drain_ready;
	assign push_fire   = push_valid && write_buffer_ready && !sleep_sync_reg;
	assign drain_fire  = drain_valid && drain_ready;
	// R9: qualifier high freezes the pipeline; a push refused by a full buffer in sleep also stalls it
	assign pipe_en = !clock_qualify_n && !(push_valid && !write_buffer_ready);

	// =========================================================
	// Cycle decode
	// =========================================================
	always @* begin
		op_next        = `PSC_OP_DESEL;
		burst_next     = burst_reg;
		base_addr_next = base_addr_reg;
		cnt_next       = cnt_reg;
		acc_addr_next  = s1_addr_reg;
		if (!advance_load) begin
			base_addr_next = addr;
			cnt_next       = `PSC_CNT_RESET;
			acc_addr_next  = addr;
			if (!all_selected) begin
				// R17: deselect
				op_next    = `PSC_OP_DESEL;
				burst_next = `PSC_BURST_NONE;
			end else if (write_n) begin
				// R1: begin read; R14: strobe high ignores lanes
				op_next    = `PSC_OP_READ;
				burst_next = `PSC_BURST_READ;
			end else begin
				// R5: begin write; R7: no lanes means abort
				op_next    = lanes_active ? `PSC_OP_WRITE : `PSC_OP_ABORT;
				burst_next = `PSC_BURST_WRITE;
			end
		end else begin
			cnt_next      = cnt_reg + `PSC_CNT_ONE;
			// R19: burst order from the mode pin
			acc_addr_next = {base_addr_reg[`PSC_ADDR_W-1:2],
				burst_low(base_addr_reg[1:0], cnt_next, mode_sync_reg)};
			case (burst_reg)
				// R2: read continues, selects and strobe ignored
				`PSC_BURST_READ:  op_next = `PSC_OP_READ;
				// R6: write continues; R8: no lanes advances only
				`PSC_BURST_WRITE: op_next = lanes_active ? `PSC_OP_WRITE : `PSC_OP_ABORT;
				// R17: continue deselect
				default: begin
					op_next  = `PSC_OP_DESEL;
					cnt_next = cnt_reg;
				end
			endcase
		end
	end

	// =========================================================
	// Read with forwarding of pending writes
	// =========================================================
	// Oldest entry merged first so newer bytes win
	always @* begin
		rd_data_next = mem_reg[s1_addr_reg];
		if (drain_valid && ent_addr_reg[rd_ptr_reg] == s1_addr_reg)
			rd_data_next = lane_merge(rd_data_next, ent_data_reg[rd_ptr_reg],
				ent_lanes_reg[rd_ptr_reg]);
		if (buf_full && ent_addr_reg[!rd_ptr_reg] == s1_addr_reg)
			rd_data_next = lane_merge(rd_data_next, ent_data_reg[!rd_ptr_reg],
				ent_lanes_reg[!rd_ptr_reg]);
		if (push_valid && s2_addr_reg == s1_addr_reg)
			rd_data_next = lane_merge(rd_data_next, push_word, s2_lanes_reg);
	end

	// =========================================================
	// Pipeline registers
	// =========================================================
	always @(posedge mclk) begin
		// Sleep clears stage state even on an unqualified edge
		if (!rstn || sleep_sync_reg) begin
			// R10: powers up deselected; R18: sleep drops pending accesses
			burst_reg     <= `PSC_BURST_NONE;
			base_addr_reg <= {`PSC_ADDR_W{1'b0}};
			cnt_reg       <= `PSC_CNT_RESET;
			s1_op_reg     <= `PSC_OP_DESEL;
			s1_addr_reg   <= {`PSC_ADDR_W{1'b0}};
			s1_lanes_reg  <= `PSC_LANES_IDLE;
			s2_op_reg     <= `PSC_OP_DESEL;
			s2_addr_reg   <= {`PSC_ADDR_W{1'b0}};
			s2_lanes_reg  <= `PSC_LANES_IDLE;
			rd_data_reg   <= {`PSC_WORD_W{1'b0}};
		end else if (pipe_en) begin
			burst_reg     <= burst_next;
			base_addr_reg <= base_addr_next;
			cnt_reg       <= cnt_next;
			s1_op_reg     <= op_next;
			s1_addr_reg   <= acc_addr_next;
			s1_lanes_reg  <= byte_lane_select;
			s2_op_reg     <= s1_op_reg;
			s2_addr_reg   <= s1_addr_reg;
			s2_lanes_reg  <= s1_lanes_reg;
			// R3: array read happens even when pins stay released
			if (s1_op_reg == `PSC_OP_READ)
				rd_data_reg <= rd_data_next;
		end
	end

	// =========================================================
	// Write buffer and array commit
	// =========================================================
	always @(posedge mclk) begin
		if (!rstn) begin
			rd_ptr_reg  <= 1'b0;
			wr_ptr_reg  <= 1'b0;
			buf_cnt_reg <= `PSC_CNT_RESET;
		end else if (!clock_qualify_n) begin
			// Drain stops in sleep; entries wait for wake
			if (drain_fire) begin
				// R15: unselected lanes keep their contents
				mem_reg[ent_addr_reg[rd_ptr_reg]] <= lane_merge(
					mem_reg[ent_addr_reg[rd_ptr_reg]], ent_data_reg[rd_ptr_reg],
					ent_lanes_reg[rd_ptr_reg]);
				rd_ptr_reg <= !rd_ptr_reg;
			end
			if (push_fire) begin
				ent_addr_reg[wr_ptr_reg]  <= s2_addr_reg;
				ent_data_reg[wr_ptr_reg]  <= push_word;
				ent_lanes_reg[wr_ptr_reg] <= s2_lanes_reg;
				wr_ptr_reg                <= !wr_ptr_reg;
			end
			// Push and drain together keep the count
			case ({push_fire, drain_fire})
				2'h2:    buf_cnt_reg <= buf_cnt_reg + `PSC_CNT_ONE;
				2'h1:    buf_cnt_reg <= buf_cnt_reg - `PSC_CNT_ONE;
				default: buf_cnt_reg <= buf_cnt_reg;
			endcase
		end
	end

	// =========================================================
	// Pin drivers
	// =========================================================
	// R12: drive enable is combinational and masked by writes
	// R11: write and abort cycles never drive
	// R13: only a selected read with drive enable active drives
	// R4: continued read with drive enable inactive stays released
	assign data_io_oe    = (s2_op_reg == `PSC_OP_READ) && !output_drive_n && !sleep_sync_reg;
	assign parity_io_oe  = data_io_oe;
	// Read data holds until the next read reaches stage two or reset or sleep clears it
	assign data_io_out   = rd_data_reg[`PSC_DATA_W-1:0];
	assign parity_io_out = rd_data_reg[`PSC_WORD_W-1:`PSC_DATA_W];

endmodule // psc_sram

// ==== psc_sram_checker.sv ====
// Port assertions for the burst SRAM cycle decoder
`timescale 1ns/1ps
`include "psc_defines.vh"
// ======
// Checker
module psc_sram_chk (
	input wire                   mclk,
	input wire                   rstn,
	input wire                   clock_qualify_n,
	input wire                   sleep_request,
	input wire                   chip_sel1_n,
	input wire                   chip_sel2,
	input wire                   chip_sel3_n,
	input wire                   advance_load,
	input wire                   write_n,
	input wire                   output_drive_n,
	input wire [`PSC_DATA_W-1:0] data_io_out,
	input wire                   data_io_oe,
	input wire                   parity_io_oe,
	input wire                   sleep_active,
	input wire                   write_buffer_ready
);
	wire sel = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
	wire q = !clock_qualify_n && !sleep_active && write_buffer_ready;
	wire ld = q && !advance_load;
	wire rd = ld && sel && write_n;
	wire wr = ld && sel && !write_n;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	chk_read_drive: assert property (rd ##1 q |-> ##1 (sleep_active || data_io_oe != output_drive_n))
		else $error("read drive wrong");
	chk_write_float: assert property (wr ##1 q |-> ##1 !data_io_oe)
		else $error("write not released");
	chk_desel_float: assert property (ld && !sel ##1 q |-> ##1 !data_io_oe)
		else $error("deselect not released");
	chk_drive_gate: assert property (output_drive_n |-> !data_io_oe)
		else $error("drive while disabled");
	chk_parity_oe: assert property (data_io_oe == parity_io_oe)
		else $error("parity drive differs");
	chk_stall_hold: assert property (clock_qualify_n && !sleep_active |=> $stable(data_io_out))
		else $error("stall changed data");
	chk_sleep_enter: assert property ($rose(sleep_request) ##1 sleep_request |->
		!sleep_active ##1 sleep_active)
		else $error("sleep not entered");
	chk_sleep_exit: assert property ($fell(sleep_request) ##1 !sleep_request |->
		sleep_active ##1 !sleep_active)
		else $error("sleep not left");
	chk_sleep_float: assert property (sleep_active |-> !data_io_oe)
		else $error("drive while asleep");
	chk_power_up: assert property (disable iff (1'b0) !rstn |=> !data_io_oe)
		else $error("drive after reset");
	chk_buffer_ready: assert property (!sleep_active |-> write_buffer_ready)
		else $error("write buffer refused while awake");
	cover property (rd ##2 data_io_oe);
	cover property (wr);
	cover property (sleep_active);
endmodule // psc_sram_chk

bind psc_sram psc_sram_chk chk_u (.mclk, .rstn, .clock_qualify_n, .sleep_request, .chip_sel1_n,
	.chip_sel2, .chip_sel3_n, .advance_load, .write_n, .output_drive_n, .data_io_out,
	.data_io_oe, .parity_io_oe, .sleep_active, .write_buffer_ready);

// ==== psc_sram_tb.sv ====
// Self-checking bench for the burst SRAM cycle decoder
`timescale 1ns/1ps
`include "psc_defines.vh"
// ======
// Bench
module psc_sram_tb;
	logic mclk = 0, rstn = 0, clock_qualify_n = 0, sleep_request = 0, burst_mode = 1;
	logic chip_sel1_n = 1, chip_sel2 = 0, chip_sel3_n = 1, advance_load = 0, write_n = 1;
	logic output_drive_n = 0, wr_req = 0, data_io_oe, parity_io_oe, sleep_active;
	logic write_buffer_ready;
	logic [3:0] byte_lane_select = 4'hF, parity_io_in, parity_io_out, s1l, s2l;
	logic [17:0] addr = 18'h0, s1a, s2a, base;
	logic [31:0] data_io_in, data_io_out, seed = 32'hC112;
	logic [35:0] wr_word = 36'h0, mem [0:15];
	logic [1:0] s1k = 0, s2k = 0, bk = 0, cnt = 0;
	int errors = 0, num_checks = 0;
	wire sel = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
	always #50 mclk = ~mclk;
	psc_sram dut_u (.mclk, .rstn, .clock_qualify_n, .sleep_request, .burst_mode, .chip_sel1_n,
		.chip_sel2, .chip_sel3_n, .advance_load, .write_n, .byte_lane_select, .output_drive_n,
		.addr, .data_io_in, .data_io_out, .data_io_oe, .parity_io_in, .parity_io_out,
		.parity_io_oe, .sleep_active, .write_buffer_ready);
	psc_ctrl_model ctrl_u (.mclk, .qual(!clock_qualify_n && !sleep_active), .wr_req,
		.wr_word, .data_io_in, .parity_io_in);
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic [17:0] step(logic [17:0] b, logic [1:0] c);
		return {b[17:2], burst_mode ? b[1:0] ^ c : b[1:0] + c};
	endfunction
	task chk(string nm, logic [35:0] seen, logic [35:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task end_sim();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Kinds: 0 deselect, 1 read, 2 write, 3 continue, 4 stall
	task op(int kd, logic [17:0] a, logic [3:0] ln, logic od);
		@(negedge mclk);
		clock_qualify_n = kd == 4;
		advance_load = kd == 3;
		{chip_sel1_n, chip_sel2, chip_sel3_n} = kd == 0 ? 3'h2 ^ (3'h1 << rnd() % 3) :
			kd == 3 ? 3'(rnd()) : 3'h2;
		write_n = kd == 1 || (kd != 2 && rnd() % 2);
		byte_lane_select = ln;
		output_drive_n = od;
		addr = a;
		wr_req = kd == 2 || (kd == 3 && bk == 2);
		wr_word = {4'(rnd()), rnd()};
	endtask
	// Reference pipeline at each accepted edge
	always @(posedge mclk) begin
		if (!rstn || sleep_active) begin
			s1k = 0;
			s2k = 0;
			bk = 0;
		end else if (!clock_qualify_n) begin
			chk("oe", {data_io_oe, parity_io_oe}, {2{s2k == 1 && !output_drive_n}});
			chk("ready", write_buffer_ready, 1);
			if (s2k == 1 && !output_drive_n)
				chk("rdata", {parity_io_out, data_io_out}, mem[s2a[3:0]]);
			if (s2k == 2)
				for (int i = 0; i < 4; i++)
					if (!s2l[i]) begin
						mem[s2a[3:0]][8*i+:8] = data_io_in[8*i+:8];
						mem[s2a[3:0]][32+i] = parity_io_in[i];
					end
			s2k = s1k;
			s2a = s1a;
			s2l = s1l;
			if (!advance_load) begin
				base = addr;
				cnt = 0;
				bk = !sel ? 2'h0 : write_n ? 2'h1 : 2'h2;
			end else if (bk != 0)
				cnt++;
			s1k = bk == 2 && &byte_lane_select ? 2'h3 : bk;
			s1a = step(base, cnt);
			s1l = byte_lane_select;
		end
	end
	initial begin
		#1ms;
		errors++;
		end_sim();
	end
	initial begin
		repeat (6) @(negedge mclk);
		rstn = 1;
		chk("rst_data", {parity_io_out, data_io_out}, 36'h0);
		for (int i = 0; i < 16; i += 4) begin
			op(2, i, 4'h0, 1);
			repeat (3) op(3, 0, 4'h0, 1);
		end
		op(2, 5, 4'hE, 0);
		op(3, 0, 4'hB, 0);
		op(3, 0, 4'hF, 0);
		op(4, 0, 4'h0, 0);
		op(3, 0, 4'h7, 0);
		op(2, 9, 4'hF, 0);
		op(3, 0, 4'h6, 0);
		op(1, 5, 4'h0, 0);
		repeat (4) op(3, 0, 4'hF, 0);
		op(1, 9, 4'hF, 1);
		op(3, 0, 4'hF, 1);
		op(1, 10, 4'hF, 0);
		for (int m = 0; m < 2; m++) begin
			repeat (300) op(rnd() % 5, rnd() % 16, 4'(rnd()), 1'(rnd()));
			repeat (4) op(0, 0, 4'hF, 1);
			burst_mode = m;
			repeat (4) op(0, 0, 4'hF, 1);
		end
		sleep_request = 1;
		repeat (5) op(0, 0, 4'hF, 0);
		chk("sleep", sleep_active, 1);
		sleep_request = 0;
		repeat (5) op(0, 0, 4'hF, 0);
		chk("wake", sleep_active, 0);
		op(1, 5, 4'hF, 0);
		repeat (3) op(0, 0, 4'hF, 0);
		end_sim();
	end
endmodule // psc_sram_tb
